//--- design/ssadc_pkg.sv
// Shared constants and types of the serial SAR converter sequencer
// How it works
// RULE1: Select falling drives output with previous MSB
// RULE2: Select rising floats output, disables clock/address
// RULE3: Host gives 11 to 16 clocks, select toggled
// RULE4: Host gives exactly 16 clocks, select held
// RULE5: Fast held mode: conversion done presents MSB
// RULE6: Slow held mode: sixteenth fall presents MSB
// RULE7: Slow modes: eleventh rise precedes conversion end
// RULE8: Late eleventh rise loses sync until reselect
// RULE9: Eleventh rise within 9.5 us of tenth fall
// RULE10: Channel code captured MSB first, four rises
// RULE11: Code selects among fourteen converter inputs
// RULE12: Codes 0 to 10 pick external channels
// RULE13: Codes 11,12,13 pick mid, low, high references
// RULE14: Multiplexer opens old path before closing new
// RULE15: Sampling from fourth fall for six periods
// RULE16: Hold from tenth fall, conversion begins
// RULE17: Resolve ten bits MSB first by comparison
// RULE18: Select falling starts every mode
// RULE19: Select falling mid-cycle aborts, result kept
// RULE20: Host avoids select falling near conversion end
// RULE21: Nine remaining bits follow on next falls
// RULE22: Done flag low at tenth fall, high when done
// RULE23: Output forced low from tenth fall
// RULE24: Ignore control inputs for setup plus two cycles
// RULE25: Cycles per resolved bit are a parameter
package ssadc_pkg;
    localparam int RES_W = 10;
    localparam int ADDR_W = 4;
    localparam int NUM_IN = 14;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] POS_ADDR_LAST = 5'h03;
    localparam logic [CNT_W-1:0] POS_SAMPLE = 5'h03;
    localparam logic [CNT_W-1:0] POS_TENTH = 5'h09;
    localparam logic [CNT_W-1:0] POS_MIN_RISE = 5'h0B;
    localparam logic [CNT_W-1:0] POS_LAST = 5'h10;
    localparam logic [3:0] POS_SHIFT_TOP = 4'h8;
    localparam logic [RES_W-1:0] SAR_FIRST = 10'h200;
    localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
    localparam logic [ADDR_W-1:0] CODE_EXT_LAST = 4'hA;
    localparam logic [ADDR_W-1:0] CODE_TEST_MID = 4'hB;
    localparam logic [ADDR_W-1:0] CODE_TEST_LOW = 4'hC;
    localparam logic [ADDR_W-1:0] CODE_TEST_HIGH = 4'hD;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SETUP_NS = 1425;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
    localparam int SETUP_W = 8;
    localparam int BIT_CYC_DEF = 8;
    localparam int BBM_CYC_DEF = 2;
    localparam int BBM_W = 4;

    typedef enum logic [1:0] {
        SS_OFF = 2'b00,
        SS_SETUP = 2'b01,
        SS_RUN = 2'b10,
        SS_LOST = 2'b11
    } ssadc_sess_t;

    // Analog front-end controls: index 0..10 external, 11 mid, 12 low, 13 high
    typedef struct packed {
        logic sample;
        logic [NUM_IN-1:0] mux_sel;
        logic [RES_W-1:0] dac_code;
    } ssadc_afe_t;
endpackage

//--- design/ssadc_seq.sv
// Sequencer, serial port and SAR control of the converter
`timescale 1ns/100ps
module ssadc_seq
    import ssadc_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYC_DEF,
    parameter int BBM_CYC = BBM_CYC_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic addr_in,
    input wire logic comp_above,
    output logic data_out,
    output logic data_oe_b,
    output logic eoc,
    output ssadc_afe_t afe
);
    // Comparator passes two flops and the front-end register adds one
    if (BIT_CYC < 5 || BIT_CYC > 255) begin : g_bad_bit
        $error("BIT_CYC must lie in 5..255");
    end
    if (BBM_CYC < 1 || BBM_CYC > 15) begin : g_bad_bbm
        $error("BBM_CYC must lie in 1..15");
    end

    function automatic logic [CNT_W-1:0] to_gray(input logic [CNT_W-1:0] b);
        return b ^ (b >> 1);
    endfunction
    function automatic logic [CNT_W-1:0] from_gray(input logic [CNT_W-1:0] g);
        logic [CNT_W-1:0] b;
        b[CNT_W-1] = g[CNT_W-1];
        for (int i = CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction
    function automatic logic [NUM_IN-1:0] decode_chan(input logic [ADDR_W-1:0] code);
        logic [NUM_IN-1:0] sel;
        sel = '0;
        if (code <= CODE_TEST_HIGH) begin
            sel[code] = 1'b1;
        end
        return sel;
    endfunction
    logic [1:0] rst_sync;
    logic rst_int_b;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_int_b = rst_sync[1];
    // Link side: counts shift-clock edges, gray coded for the crossing
    logic link_en;
    logic [CNT_W-1:0] rise_cnt, fall_cnt, rise_g, fall_g;
    logic [ADDR_W-1:0] addr_sh;
    // Cleared while control inputs are disabled; host waits the setup time first
    always_ff @(posedge sclk or negedge link_en) begin
        if (!link_en) begin
            rise_cnt <= '0;
            rise_g <= '0;
            addr_sh <= '0;
        end else begin
            rise_cnt <= CNT_W'(rise_cnt + 1'b1);
            rise_g <= to_gray(CNT_W'(rise_cnt + 1'b1));
            if (rise_cnt[3:0] <= POS_ADDR_LAST[3:0]) begin
                addr_sh <= {addr_sh[ADDR_W-2:0], addr_in}; // RULE10
            end
        end
    end

    always_ff @(negedge sclk or negedge link_en) begin
        if (!link_en) begin
            fall_cnt <= '0;
            fall_g <= '0;
        end else begin
            fall_cnt <= CNT_W'(fall_cnt + 1'b1);
            fall_g <= to_gray(CNT_W'(fall_cnt + 1'b1));
        end
    end

    // System side crossings
    logic [1:0] cs_sync;
    logic cs_lo, cs_lo_d, cs_enter;
    logic [1:0] comp_sync;
    logic [CNT_W-1:0] rise_s1, rise_s2, fall_s1, fall_s2, rise_seen, fall_seen;
    logic rise_evt, fall_evt;
    ssadc_sess_t state;
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            cs_sync <= 2'b11;
            cs_lo_d <= 1'b0;
            comp_sync <= 2'b00;
        end else begin
            cs_sync <= {cs_sync[0], cs_b};
            cs_lo_d <= ~cs_sync[1];
            comp_sync <= {comp_sync[0], comp_above};
        end
    end
    assign cs_lo = ~cs_sync[1];
    assign cs_enter = cs_lo && !cs_lo_d;
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            rise_s1 <= '0;
            rise_s2 <= '0;
            fall_s1 <= '0;
            fall_s2 <= '0;
            rise_seen <= '0;
            fall_seen <= '0;
        end else begin
            rise_s1 <= rise_g;
            rise_s2 <= rise_s1;
            fall_s1 <= fall_g;
            fall_s2 <= fall_s1;
            rise_seen <= from_gray(rise_s2);
            fall_seen <= from_gray(fall_s2);
        end
    end
    // Edges are far apart against clk, so at most one step per cycle
    assign rise_evt = (from_gray(rise_s2) != rise_seen) && state == SS_RUN;
    assign fall_evt = (from_gray(fall_s2) != fall_seen) && state == SS_RUN;
    // Conversion datapath signals
    logic busy;
    logic [7:0] cyc;
    logic [RES_W-1:0] trial, wmask, result, kept;
    logic step_end, conv_done, abort, start, lose, restart, res_msb, msb_now, shift_bit;
    logic [CNT_W-1:0] fpos, rpos;
    logic [SETUP_W-1:0] setup_cnt;
    assign start = fall_evt && fpos == POS_TENTH;
    assign abort = cs_enter && busy;
    assign step_end = busy && cyc == 8'(BIT_CYC - 1);
    assign kept = comp_sync[1] ? trial : (trial & ~wmask);
    assign conv_done = step_end && wmask[0] && !abort;
    assign res_msb = conv_done ? kept[RES_W-1] : result[RES_W-1];
    assign msb_now = result[RES_W-1];
    assign shift_bit = result[POS_SHIFT_TOP - fpos[3:0]];
    assign lose = conv_done && state == SS_RUN && rpos < POS_MIN_RISE && fpos != POS_LAST;
    assign restart = (fall_evt && fpos == POS_LAST - 1'b1 && (!busy || conv_done))
        || (conv_done && state == SS_RUN && fpos == POS_LAST);
    // Session: select, setup wait, running, lost
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            state <= SS_OFF;
            setup_cnt <= '0;
            link_en <= 1'b0;
        end else if (!cs_lo) begin
            state <= SS_OFF; // RULE2
            link_en <= 1'b0;
        end else begin
            unique case (state)
                SS_OFF: begin
                    state <= SS_SETUP; // RULE18
                    setup_cnt <= '0;
                end
                SS_SETUP: begin
                    setup_cnt <= SETUP_W'(setup_cnt + 1'b1);
                    if (setup_cnt == SETUP_W'(SETUP_CYC - 1)) begin
                        state <= SS_RUN; // RULE24
                        link_en <= 1'b1;
                    end
                end
                SS_RUN: begin
                    if (lose) begin
                        state <= SS_LOST; // RULE8
                        link_en <= 1'b0;
                    end
                end
                SS_LOST: begin
                    state <= SS_LOST;
                end
            endcase
        end
    end

    // Frame position on the system side
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            fpos <= '0;
            rpos <= '0;
        end else if (state != SS_RUN || restart) begin
            fpos <= '0;
            rpos <= '0;
        end else begin
            if (fall_evt && fpos != POS_LAST) begin
                fpos <= CNT_W'(fpos + 1'b1);
            end
            if (rise_evt && rpos != POS_LAST) begin
                rpos <= CNT_W'(rpos + 1'b1);
            end
        end
    end

    // Serial output
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            data_oe_b <= 1'b1;
            data_out <= 1'b0;
        end else if (!cs_lo) begin
            data_oe_b <= 1'b1; // RULE2
            data_out <= 1'b0;
        end else if (cs_enter) begin
            data_oe_b <= 1'b0; // RULE1
            data_out <= msb_now;
        end else if (restart) begin
            data_out <= res_msb; // RULE5 RULE6
        end else if (fall_evt && fpos < POS_TENTH) begin
            data_out <= shift_bit; // RULE21
        end else if (start) begin
            data_out <= 1'b0; // RULE23
        end
    end

    // Successive approximation, one trial per BIT_CYC cycles
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            busy <= 1'b0;
            cyc <= '0;
            trial <= '0;
            wmask <= '0;
        end else if (abort) begin
            busy <= 1'b0; // RULE19
            trial <= '0;
            wmask <= '0;
        end else if (start) begin
            busy <= 1'b1; // RULE16
            cyc <= '0;
            trial <= SAR_FIRST; // RULE17
            wmask <= SAR_FIRST;
        end else if (busy) begin
            if (step_end) begin
                cyc <= '0; // RULE25
                wmask <= wmask >> 1;
                trial <= kept | (wmask >> 1); // RULE17
                if (wmask[0]) begin
                    busy <= 1'b0;
                end
            end else begin
                cyc <= 8'(cyc + 1'b1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            result <= RESULT_RST;
        end else if (conv_done) begin
            result <= kept;
        end
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            eoc <= 1'b1;
        end else if (abort || conv_done) begin
            eoc <= 1'b1; // RULE22
        end else if (start) begin
            eoc <= 1'b0; // RULE22
        end
    end

    // Sampling window and input multiplexer
    logic sample;
    logic [ADDR_W-1:0] chan;
    logic [NUM_IN-1:0] mux_sel;
    logic [BBM_W-1:0] bbm_cnt;
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            sample <= 1'b0;
        end else if (state != SS_RUN || start) begin
            sample <= 1'b0; // RULE16
        end else if (fall_evt && fpos == POS_SAMPLE) begin
            sample <= 1'b1; // RULE15
        end
    end

    // Codes above the high test level leave every path open
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            chan <= '1; // No path matches, so the first code closes one
            mux_sel <= '0;
            bbm_cnt <= '0;
        end else if (rise_evt && rpos == POS_ADDR_LAST && addr_sh != chan) begin
            chan <= addr_sh; // RULE10
            mux_sel <= '0; // RULE14
            bbm_cnt <= BBM_W'(BBM_CYC);
        end else if (bbm_cnt != '0) begin
            bbm_cnt <= BBM_W'(bbm_cnt - 1'b1);
            if (bbm_cnt == BBM_W'(1)) begin
                mux_sel <= decode_chan(chan); // RULE11 RULE12 RULE13
            end
        end
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            afe <= '0;
        end else begin
            afe.sample <= sample;
            afe.mux_sel <= mux_sel;
            afe.dac_code <= trial;
        end
    end
    // Checks
    localparam int A_CONV_MAX = 10 * BIT_CYC;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_int_b);
    sequence s_select;
        cs_enter;
    endsequence
    sequence s_tenth;
        start && !abort;
    endsequence
    property p_msb_on_select;
        s_select |=> !data_oe_b && data_out == $past(msb_now);
    endproperty
    a_msb_on_select: assert property (p_msb_on_select) else $error("MSB not on select"); // RULE1
    property p_release;
        !cs_lo |=> data_oe_b && !link_en;
    endproperty
    a_release: assert property (p_release) else $error("output not released"); // RULE2
    property p_setup_wait;
        s_select |=> !link_en [*8];
    endproperty
    a_setup_wait: assert property (p_setup_wait) else $error("inputs enabled early"); // RULE24
    property p_tenth_eoc;
        s_tenth |=> !eoc && busy;
    endproperty
    a_tenth_eoc: assert property (p_tenth_eoc) else $error("done flag not low"); // RULE22
    property p_tenth_low;
        s_tenth ##1 cs_lo |-> !data_out;
    endproperty
    a_tenth_low: assert property (p_tenth_low) else $error("output not low"); // RULE23
    property p_hold;
        s_tenth |=> ##1 !afe.sample;
    endproperty
    a_hold: assert property (p_hold) else $error("sample not held"); // RULE16
    property p_sample_start;
        fall_evt && fpos == POS_SAMPLE |=> ##1 afe.sample;
    endproperty
    a_sample_start: assert property (p_sample_start) else $error("sampling late"); // RULE15
    property p_conv_len;
        $rose(busy) |-> ##[1:A_CONV_MAX] !busy;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion overran"); // RULE25
    property p_abort;
        s_select and busy |=> !busy && eoc && $stable(result);
    endproperty
    a_abort: assert property (p_abort) else $error("abort failed"); // RULE19
    property p_fast_held;
        conv_done && state == SS_RUN && fpos == POS_LAST && cs_lo |=> data_out == $past(kept[9]);
    endproperty
    a_fast_held: assert property (p_fast_held) else $error("MSB not on done"); // RULE5
    property p_shift;
        fall_evt && fpos < POS_TENTH && cs_lo && !cs_enter |=> data_out == $past(shift_bit);
    endproperty
    a_shift: assert property (p_shift) else $error("bad shifted bit"); // RULE21
    property p_bbm;
        $changed(afe.mux_sel) && afe.mux_sel != '0 |-> $past(afe.mux_sel) == '0;
    endproperty
    a_bbm: assert property (p_bbm) else $error("make before break"); // RULE14
    property p_lose;
        lose && cs_lo |=> state == SS_LOST ##1 !link_en;
    endproperty
    a_lose: assert property (p_lose) else $error("sync loss missed"); // RULE8
endmodule

//--- verif/ssadc_host.sv
// Host serial port model: select, shift clock, address, result capture
`timescale 1ns/100ps
module ssadc_host (
    output logic sclk,
    output logic cs_b,
    output logic addr_in,
    input wire logic data_out,
    input wire logic data_oe_b,
    input wire logic eoc
);
    logic [15:0] word;
    event got;
    event tenth;

    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        addr_in = 1'b0;
        word = 16'h0000;
    end

    task automatic frame(input logic [3:0] code, input int nclk, input logic keep,
            input logic slow, input logic wait_done);
        int i;
        logic [15:0] w;
        w = 16'h0000;
        // Selecting mid-conversion would abort it
        for (i = 0; i < 3000 && wait_done && eoc !== 1'b1; i++) #8;
        if (wait_done) #100;
        if (cs_b) begin
            #100 cs_b = 1'b0;
            // Control inputs are ignored until setup has run out
            #1600;
        end
        for (i = 0; i < nclk; i++) begin
            // Past the address the line is a don't-care, so it toggles
            addr_in = (i < 4) ? code[3 - i] : ~addr_in;
            #62.5 sclk = 1'b1;
            // Floating pin reads unknown
            w[15 - i] = (data_oe_b === 1'b0) ? data_out : 1'bx;
            if (i == 9) -> tenth;
            if (slow && i == 10) #1500;
            #62.5 sclk = 1'b0;
        end
        addr_in = ~addr_in;
        if (!keep) #100 cs_b = 1'b1;
        word = w;
        if (nclk != 0) -> got;
    endtask
endmodule

//--- verif/ssadc_seq_bench.sv
// Self-checking bench of the converter sequencer with host and analog models
`timescale 1ns/100ps
module ssadc_seq_bench;
    import ssadc_pkg::*;
    localparam int BIT_N = 12;
    localparam int LIMIT = 40000;
    logic clk;
    logic rst_b;
    logic sclk;
    logic cs_b;
    logic addr_in;
    logic comp_above;
    logic data_out;
    logic data_oe_b;
    logic eoc;
    ssadc_afe_t afe;
    logic [RES_W-1:0] vin [NUM_IN];
    logic [RES_W-1:0] held;
    logic [RES_W-1:0] last;
    logic [ADDR_W-1:0] cur;
    logic [15:0] exp_q [$];
    logic ready;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int m;
    int j;

    ssadc_seq #(.BIT_CYC(BIT_N), .BBM_CYC(BBM_CYC_DEF)) dut (
        .clk(clk),
        .rst_b(rst_b),
        .sclk(sclk),
        .cs_b(cs_b),
        .addr_in(addr_in),
        .comp_above(comp_above),
        .data_out(data_out),
        .data_oe_b(data_oe_b),
        .eoc(eoc),
        .afe(afe)
    );

    ssadc_host u_host (
        .sclk(sclk),
        .cs_b(cs_b),
        .addr_in(addr_in),
        .data_out(data_out),
        .data_oe_b(data_oe_b),
        .eoc(eoc)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Input sits half a step above its code, so equal counts as above
    assign comp_above = (held >= afe.dac_code);

    // Sampling capacitor follows the closed path while sampling
    always @(posedge clk) begin
        if (afe.sample === 1'b1) begin
            for (int k = 0; k < NUM_IN; k++) begin
                if (afe.mux_sel[k] === 1'b1) held <= vin[k];
            end
        end
        if (ready && $countones(afe.mux_sel) > 1) chk("paths closed", 16'h0001, 16'h0002);
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic run(input logic [3:0] code, input int nclk, input logic keep,
            input logic slow, input logic wait_done, input logic takes);
        cur = code;
        if (code < CODE_TEST_MID) vin[code] = 10'($urandom_range(0, 1023));
        if (nclk != 0) exp_q.push_back({last, 6'h00});
        u_host.frame(code, nclk, keep, slow, wait_done);
        // Open paths leave the last sample on the capacitor
        if (takes) last = (code < NUM_IN) ? vin[code] : held;
    endtask

    always @(u_host.got) begin
        if (exp_q.size() == 0) chk("unexpected word", 16'h0000, 16'hFFFF);
        else chk("result word", exp_q.pop_front(), u_host.word);
    end

    always @(u_host.tenth) begin
        #10;
        chk("sampling", 16'h0001, {15'h0000, afe.sample});
        chk("input path", (cur < NUM_IN) ? 16'h0001 << cur : 16'h0000,
            16'(afe.mux_sel));
        #100;
        chk("done flag", 16'h0000, {15'h0000, eoc});
        chk("data after tenth", 16'h0000, {15'h0000, data_out});
        chk("holding", 16'h0000, {15'h0000, afe.sample});
        // Ten trials of BIT_N cycles, plus crossing margin
        repeat (10 * BIT_N + 10) @(posedge clk);
        #1;
        chk("done flag high", 16'h0001, {15'h0000, eoc});
    end

    always @(posedge cs_b) begin
        if (ready) begin
            repeat (6) @(posedge clk);
            #1;
            chk("output released", 16'h0001, {15'h0000, data_oe_b});
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fail_count++;
            $display("[ERR] run cycles expected below %0d seen %0d", LIMIT, cyc);
            close_out();
        end
    end

    initial begin
        rst_b = 1'b0;
        ready = 1'b0;
        last = RESULT_RST;
        held = 10'h000;
        cur = 4'h0;
        void'($urandom(32'h7FB2));
        for (j = 0; j < NUM_IN; j++) vin[j] = 10'h000;
        vin[CODE_TEST_MID] = 10'h200;
        vin[CODE_TEST_LOW] = 10'h000;
        vin[CODE_TEST_HIGH] = 10'h3FF;
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        ready = 1'b1;
        // Codes 0 to 13, select toggled, fast and slow, 11 to 16 clocks
        for (j = 0; j < NUM_IN; j++) begin
            run(4'(j), 11 + $urandom_range(0, 5), 1'b0, j[0], 1'b1, 1'b1);
        end
        $display("toggled select frames done");
        // Select held low: fast then slow, last frame releases
        for (m = 0; m < 2; m++) begin
            for (j = 0; j < 4; j++) begin
                run(4'($urandom_range(0, 13)), 16, j < 3, m[0], 1'b1, 1'b1);
            end
        end
        $display("held select frames done");
        // Select falls again while converting
        run(4'($urandom_range(0, 10)), 12, 1'b0, 1'b0, 1'b1, 1'b0);
        run(4'($urandom_range(0, 10)), 11, 1'b0, 1'b0, 1'b0, 1'b1);
        run(CODE_TEST_LOW, 11, 1'b0, 1'b0, 1'b1, 1'b1);
        // Unused code: every path stays open
        run(4'hE, 11, 1'b0, 1'b1, 1'b1, 1'b1);
        $display("abort done");
        // Ten clocks with select held lose sync; toggling recovers
        run(CODE_TEST_HIGH, 11, 1'b0, 1'b0, 1'b1, 1'b1);
        run(CODE_TEST_HIGH, 10, 1'b1, 1'b0, 1'b1, 1'b1);
        #2000;
        run(CODE_TEST_HIGH, 0, 1'b0, 1'b0, 1'b0, 1'b0);
        run(4'h5, 11, 1'b0, 1'b0, 1'b1, 1'b1);
        run(4'h5, 11, 1'b0, 1'b0, 1'b1, 1'b1);
        $display("sync loss done");
        #2000;
        close_out();
    end
endmodule
